// ===== test/pfh_flash_model.sv
`timescale 1ns/1ps
module pfh_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5C,
  parameter logic [7:0] DEV_CODE = 8'h3B,
  parameter logic [2:0] PROT_GRP = 3'h1,
  parameter int BUSY_NS = 120
) (
  input wire pfh_pkg::pfh_pins_s pins,
  output logic [7:0] dq,
  output logic busy_n
);
  logic [7:0] mem [logic [20:0]];
  logic [20:0] wa;
  logic [7:0] last = 8'h00;
  logic wr = 1'b0;
  initial busy_n = 1'b1;
  always @(negedge pins.chip_sel_n or negedge pins.write_strobe_n) begin
    if (!pins.chip_sel_n && !pins.write_strobe_n) begin
      wa = pins.addr;
      wr = 1'b1;
    end
  end
  // Groups of four adjacent 64 Kbyte blocks; one group is protected
  always @(posedge pins.chip_sel_n or posedge pins.write_strobe_n) begin
    if (wr && (wa[20:18] != PROT_GRP || pins.reset_high_level)) mem[wa] = pins.data_out;
    wr = 1'b0;
  end
  always @* begin
    if (!pins.chip_sel_n && !pins.out_drive_n && pins.write_strobe_n) begin
      if (pins.a9_high_level) dq = pins.addr[0] ? DEV_CODE : MFR_CODE;
      else dq = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
      last = dq;
    end else begin
      dq = ~last;
    end
  end
  // Released busy goes to the pull-up
  always @(negedge pins.reset_unprotect_n) busy_n = 1'b0;
  always @(posedge pins.reset_unprotect_n) busy_n <= #(BUSY_NS) 1'b1;
endmodule

// ===== test/pfh_host_sva.sv
`timescale 1ns/1ps
module pfh_host_sva #(
  parameter int RST_PULSE_CYC = 13
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire pfh_pkg::pfh_pins_s pins,
  input wire logic busy_flag_n
);
  // A pulse cut short leaves the flash half reset
  int lo;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) lo <= 0;
    else if (pins.reset_unprotect_n) lo <= 0;
    else lo <= lo + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_write_od_high: assert property (!pins.write_strobe_n |-> pins.out_drive_n)
    else $error("read strobe in write");
  a_strobe_in_cs: assert property (!(pins.out_drive_n && pins.write_strobe_n)
    |-> !pins.chip_sel_n) else $error("strobe outside select");
  a_data_at_rise: assert property ($rose(pins.write_strobe_n)
    |-> !pins.data_oe_n && $stable(pins.data_out)) else $error("data not held");
  a_addr_held: assert property (!pins.chip_sel_n && !$past(pins.chip_sel_n)
    |-> $stable(pins.addr)) else $error("address moved");
  a_rst_pulse_len: assert property ($rose(pins.reset_unprotect_n)
    |-> lo >= RST_PULSE_CYC) else $error("reset pulse short");
  a_busy_blocks: assert property (!busy_flag_n |-> !req_ready)
    else $error("ready while busy");
  a_rsp_at_end: assert property (rsp_valid |-> $rose(pins.out_drive_n))
    else $error("response off strobe");
  a_sig_addr: assert property (pins.a9_high_level && !pins.chip_sel_n
    |-> !pins.addr[1]) else $error("signature address");
endmodule

bind pfh_host pfh_host_sva #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_sva (.clk_sys(clk_sys),
  .arst_n(arst_n), .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins),
  .busy_flag_n(busy_flag_n));

// ===== test/pfh_host_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module pfh_host_tb;
  localparam logic [7:0] MFR = 8'h5C; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3B; // Arbitrary value
  localparam logic [2:0] PROT = 3'h1;
  logic clk_sys = 0, arst_n = 0, tb_busy_n = 1, req_valid = 0, req_ready, rsp_valid, dev_busy_n;
  logic [7:0] rsp_data, dq, ex;
  logic [31:0] seed = 32'h97A7, r;
  pfh_pkg::pfh_req_s req = '0;
  pfh_pkg::pfh_pins_s pins;
  wire busy_flag_n = dev_busy_n & tb_busy_n;
  int mismatches = 0, comparisons = 0, cyc = 0;
  logic [7:0] img [logic [20:0]];
  logic [7:0] exp_q [$];
  always #20 clk_sys = ~clk_sys;
  pfh_host u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .byte_data_lines_in(dq), .busy_flag_n(busy_flag_n));
  pfh_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT_GRP(PROT)) u_flash (.pins(pins),
    .dq(dq), .busy_n(dev_busy_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input pfh_pkg::pfh_op_e op, input logic u, input logic [20:0] a,
                      input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    req = '{op, u, a, d};
    req_valid = 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    #2;
    req_valid = 1'b0;
    case (op)
      pfh_pkg::PFH_OP_WRITE: if (a[20:18] != PROT || u) img[a] = d;
      pfh_pkg::PFH_OP_READ: exp_q.push_back(img.exists(a) ? img[a] : 8'hFF);
      pfh_pkg::PFH_OP_SIG_MFR: exp_q.push_back(MFR);
      pfh_pkg::PFH_OP_SIG_DEV: exp_q.push_back(DEV);
      default: ;
    endcase
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
    if (rsp_valid === 1'b1) begin
      ex = exp_q.size() ? exp_q.pop_front() : 8'hXX;
      `CHK("rsp_data", ex, rsp_data)
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    #2 arst_n = 1;
    repeat (12) begin
      r = xs();
      send(pfh_pkg::PFH_OP_WRITE, r[29], r[20:0], r[28:21]);
      send(pfh_pkg::PFH_OP_READ, 1'b0, r[20:0], 8'h00);
    end
    for (int j = 0; j < 2; j++) begin
      send(pfh_pkg::PFH_OP_WRITE, j[0], {PROT, 18'(j)}, 8'h3C);
      send(pfh_pkg::PFH_OP_READ, 1'b0, {PROT, 18'(j)}, 8'h00);
    end
    send(pfh_pkg::PFH_OP_SIG_MFR, 1'b0, 21'(xs()), 8'h00);
    send(pfh_pkg::PFH_OP_SIG_DEV, 1'b0, 21'(xs()), 8'h00);
    send(pfh_pkg::PFH_OP_RESET, 1'b0, 21'h0, 8'h00);
    tb_busy_n = 0;
    repeat (5) @(posedge clk_sys);
    `CHK("reset_pin", 1'b0, pins.reset_unprotect_n)
    repeat (25) @(posedge clk_sys);
    `CHK("req_ready", 1'b0, req_ready)
    #2 tb_busy_n = 1;
    send(pfh_pkg::PFH_OP_READ, 1'b0, r[20:0], 8'h00);
    repeat (8) @(posedge clk_sys);
    `CHK("pending", 0, exp_q.size())
    close_out();
  end
endmodule

// ===== verilog/pfh_consts.svh
`ifndef PFH_CONSTS_SVH
`define PFH_CONSTS_SVH

// Clock period in ns
`define PFH_CLK_NS 40
// Strobe low time (host side, well above the glitch filter)
`define PFH_STROBE_NS 80
`define PFH_STROBE_CYC ((`PFH_STROBE_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
// Setup from address to falling strobe, and hold after rising
`define PFH_SETUP_NS 40
`define PFH_SETUP_CYC ((`PFH_SETUP_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
// Reset pulse minimum and recovery time
`define PFH_RST_PULSE_NS 500
`define PFH_RST_PULSE_CYC ((`PFH_RST_PULSE_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_RST_RECOV_NS 50
`define PFH_RST_RECOV_CYC ((`PFH_RST_RECOV_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
// Signature address bits
`define PFH_SIG_A0 0
`define PFH_SIG_A1 1
`define PFH_ADDR_W 21
`define PFH_DATA_W 8

`endif

// ===== verilog/pfh_host.sv
`timescale 1ns/1ps
`include "pfh_consts.svh"

// Summary of operation
// - Read: address, chip select and output drive low, write strobe high.
// - Output drive stays high for the whole bus write.
// - Reset: hold reset pin low at least the minimum, wait recovery.
// - After reset no bus cycle until ready/busy is released high.
module pfh_host #(
  parameter int STROBE_CYC = `PFH_STROBE_CYC,
  parameter int SETUP_CYC = `PFH_SETUP_CYC,
  parameter int RST_PULSE_CYC = `PFH_RST_PULSE_CYC,
  parameter int RST_RECOV_CYC = `PFH_RST_RECOV_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire pfh_pkg::pfh_req_s req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output pfh_pkg::pfh_pins_s pins,
  input wire logic [7:0] byte_data_lines_in,
  input wire logic busy_flag_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RST_LOW, ST_RST_RECOV, ST_WAIT_READY
  } pfh_state_e;

  pfh_state_e state;
  pfh_pkg::pfh_req_s cur;
  logic [15:0] cnt;
  logic is_write;

  logic take;

  function automatic logic [15:0] cyc(input int n);
    cyc = 16'(n - 1);
  endfunction

  // Signature reads raise the A9 qualifier and steer A0/A1
  function automatic logic is_sig(input pfh_pkg::pfh_op_e op);
    is_sig = (op == pfh_pkg::PFH_OP_SIG_MFR) || (op == pfh_pkg::PFH_OP_SIG_DEV);
  endfunction

  assign is_write = (cur.op == pfh_pkg::PFH_OP_WRITE);
  // Ready/busy low from any device on the shared line blocks new cycles
  assign req_ready = (state == ST_IDLE) && busy_flag_n;
  assign take = (state == ST_IDLE) && req_valid && req_ready;

  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  // Supply lockout cannot be sensed here; a lost write only shows on
  // read-back, so software should verify after power events.
  // Automatic standby needs no action: strobes sit high between cycles.
  // Address width covers 32 blocks of 64 Kbyte.

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      cur <= '0;
    end else if (clk_en) begin
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            cur <= req;
            if (req.op == pfh_pkg::PFH_OP_RESET) begin
              state <= ST_RST_LOW;
              cnt <= cyc(RST_PULSE_CYC);
            end else begin
              state <= ST_SETUP;
              cnt <= cyc(SETUP_CYC);
            end
          end
        end
        ST_SETUP: begin
          if (cnt == 16'h0000) begin
            state <= ST_STROBE;
            cnt <= cyc(STROBE_CYC);
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_STROBE: begin
          if (cnt == 16'h0000) begin
            state <= ST_HOLD;
            cnt <= cyc(SETUP_CYC);
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_HOLD: begin
          if (cnt == 16'h0000) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_RST_LOW: begin
          if (cnt == 16'h0000) begin
            state <= ST_RST_RECOV;
            cnt <= cyc(RST_RECOV_CYC);
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_RST_RECOV: begin
          if (cnt == 16'h0000) begin
            state <= ST_WAIT_READY;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_WAIT_READY: begin
          // Device holds ready/busy low until it can enter read mode
          if (busy_flag_n) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pins.addr <= '0;
      pins.chip_sel_n <= 1'b1;
      pins.out_drive_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.reset_unprotect_n <= 1'b1;
      pins.reset_high_level <= 1'b0;
      pins.a9_high_level <= 1'b0;
      pins.data_out <= 8'h00;
      pins.data_oe_n <= 1'b1;
    end else if (clk_en) begin
      pins.reset_unprotect_n <= !(take && req.op == pfh_pkg::PFH_OP_RESET)
                                && state != ST_RST_LOW;
      if (take && req.op != pfh_pkg::PFH_OP_RESET) begin
        pins.addr <= req.addr;
        // Signature reads force A1 low and choose A0, other bits don't care
        if (is_sig(req.op)) begin
          pins.addr[`PFH_SIG_A1] <= 1'b0;
          pins.addr[`PFH_SIG_A0] <= (req.op == pfh_pkg::PFH_OP_SIG_DEV);
        end
        pins.a9_high_level <= is_sig(req.op);
        // Unprotect qualifier for program/erase to protected groups
        pins.reset_high_level <= req.unprotect;
        pins.data_out <= req.data;
        pins.data_oe_n <= (req.op != pfh_pkg::PFH_OP_WRITE);
        pins.chip_sel_n <= 1'b0;
        pins.out_drive_n <= 1'b1;
      end
      if (state == ST_SETUP && cnt == 16'h0000) begin
        if (is_write) begin
          pins.write_strobe_n <= 1'b0;
        end else begin
          pins.out_drive_n <= 1'b0;
        end
      end
      if (state == ST_STROBE && cnt == 16'h0000) begin
        pins.write_strobe_n <= 1'b1;
        pins.out_drive_n <= 1'b1;
      end
      if (state == ST_HOLD && cnt == 16'h0000) begin
        pins.chip_sel_n <= 1'b1;
        pins.data_oe_n <= 1'b1;
        pins.a9_high_level <= 1'b0;
        pins.reset_high_level <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      // Sample at the end of the strobe window, when access time has passed
      if (state == ST_STROBE && cnt == 16'h0000 && !is_write) begin
        rsp_data <= byte_data_lines_in;
        rsp_valid <= 1'b1;
      end
    end
  end

endmodule

// ===== verilog/pfh_pkg.sv
package pfh_pkg;
  typedef enum logic [2:0] {
    PFH_OP_READ,
    PFH_OP_WRITE,
    PFH_OP_SIG_MFR,
    PFH_OP_SIG_DEV,
    PFH_OP_RESET
  } pfh_op_e;

  typedef struct packed {
    pfh_op_e op;
    logic unprotect;
    logic [20:0] addr;
    logic [7:0] data;
  } pfh_req_s;

  typedef struct packed {
    logic [20:0] addr;
    logic chip_sel_n;
    logic out_drive_n;
    logic write_strobe_n;
    logic reset_unprotect_n;
    logic reset_high_level;
    logic a9_high_level;
    logic [7:0] data_out;
    logic data_oe_n;
  } pfh_pins_s;
endpackage
